// ### i2c_ee_regs.svh
// Constants for the serial EEPROM slave front end
`ifndef I2C_EE_REGS_SVH
`define I2C_EE_REGS_SVH

// ==========================================================
// Slave address
`define SLAVE_ADDR_HI     4'hA
// ==========================================================
// Memory map
`define PAGE_BYTES        8
`define RESV_LO           8'h40
`define RESV_HI           8'hE7
`define SHADOW_LO         8'hF2
`define SHADOW_HI         8'hF4
`define SRAM_LO           8'hF8
`define IOCTL0_ADDR       8'hF2
`define IOCTL1_ADDR       8'hF3
`define IOCTL0_RESET      8'hFF
`define IOCTL1_RESET      8'h01
`define MEM_RESET         8'h00
// ==========================================================
// Timing
`define CLK_PERIOD_NS     8
`define NV_PROG_TIME_NS   5000000

`endif

// ### i2c_ee_pkg.sv
// Types for the serial EEPROM slave front end
package i2c_ee_pkg;
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ACK_ADDR,
        ST_MADDR,
        ST_ACK_MADDR,
        ST_WDATA,
        ST_ACK_WDATA,
        ST_TX,
        ST_RACK,
        ST_IGNORE
    } state_t;
endpackage : i2c_ee_pkg

// ### line_if.sv
// Interface carrying filtered bus events between sampler and controller
`timescale 1ns/100ps
`default_nettype none
interface line_if;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       sda_lvl;
    logic [2:0] strap;
    modport sync (output scl_rise, scl_fall, start_det, stop_det, sda_lvl, strap);
    modport ctrl (input  scl_rise, scl_fall, start_det, stop_det, sda_lvl, strap);
endinterface : line_if
`default_nettype wire

// ### i2c_line_sync.sv
// Pin sampler: three-stage synchronisers, agreement filter and bus event detection
`timescale 1ns/100ps
`default_nettype none
module i2c_line_sync (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    input  wire logic [2:0] strap_in,
    line_if.sync            lnk
);
    // Bit 4 scl, bit 3 sda, bits 2..0 straps
    logic [4:0] s1_reg, s2_reg, s3_reg, filt_reg, prev_reg;
    logic [4:0] s1_next, s2_next, s3_next, filt_next, prev_next;

    // ==========================================================
    // Synchronise and filter
    always_comb begin
        s1_next   = {scl_in, sda_in, strap_in};
        s2_next   = s1_reg;
        s3_next   = s2_reg;
        filt_next = filt_reg;
        for (int i = 0; i < 5; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                filt_next[i] = s3_reg[i];
            end
        end
        prev_next = filt_reg;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg   <= 5'h1F;
            s2_reg   <= 5'h1F;
            s3_reg   <= 5'h1F;
            filt_reg <= 5'h1F;
            prev_reg <= 5'h1F;
        end else begin
            s1_reg   <= s1_next;
            s2_reg   <= s2_next;
            s3_reg   <= s3_next;
            filt_reg <= filt_next;
            prev_reg <= prev_next;
        end
    end

    // ==========================================================
    // Edges and conditions
    assign lnk.scl_rise  = filt_reg[4] & ~prev_reg[4];
    assign lnk.scl_fall  = ~filt_reg[4] & prev_reg[4];
    assign lnk.start_det = filt_reg[4] & prev_reg[4] & prev_reg[3] & ~filt_reg[3];
    assign lnk.stop_det  = filt_reg[4] & prev_reg[4] & ~prev_reg[3] & filt_reg[3];
    assign lnk.sda_lvl   = filt_reg[3];
    assign lnk.strap     = filt_reg[2:0];
endmodule : i2c_line_sync
`default_nettype wire

// ### i2c_slave_eeprom_page_access.sv
// Two-wire slave front end with page-buffered EEPROM programming
//
// Functional notes
// - Low three slave address bits come from strap pins, ground 0, supply 1.
// - Address byte LSB 0 means master writes, 1 means master reads.
// - Mismatched slave address gets no ACK; ignore bus until next start.
// - First byte after write address is the memory address.
// - Up to eight data bytes per write; counter advances each byte.
// - Write counter wraps within the current eight-byte aligned row.
// - Stop after a page write starts one programming interval.
// - Slave address is not acknowledged while programming is in progress.
// - Programming rewrites only the buffered bytes of the page; unwritten bytes keep old values.
// - Reads start at the current address counter value.
// - Address-only write then repeated start read loads the counter.
// - Master ACKs to continue reading, NACKs last byte, then stops.
// - Bytes go MSB first with a ninth bit, low is ACK.
// - With shadow select set, shadowed writes skip programming.
// - Reserved region reads and writes have no effect.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_ee_regs.svh"
module i2c_slave_eeprom_page_access #(
    parameter int unsigned NV_PROG_CYCLES = `NV_PROG_TIME_NS / `CLK_PERIOD_NS
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic addr_strap_bit0,
    input  wire logic addr_strap_bit1,
    input  wire logic addr_strap_bit2,
    input  wire logic shadow_write_sel,
    output logic      sda_out,
    output logic      sda_oe,
    output logic      nv_busy
);
    line_if lnk ();

    i2c_line_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .strap_in ({addr_strap_bit2, addr_strap_bit1, addr_strap_bit0}),
        .lnk      (lnk.sync)
    );

    // ==========================================================
    // Address classification
    function automatic logic is_reserved(input logic [7:0] a);
        return (a >= `RESV_LO) && (a <= `RESV_HI);
    endfunction : is_reserved

    function automatic logic is_direct(input logic [7:0] a, input logic shadow);
        return (a >= `SRAM_LO) || (shadow && (a >= `SHADOW_LO) && (a <= `SHADOW_HI));
    endfunction : is_direct

    // ==========================================================
    // Storage
    logic [7:0] mem [256];
    logic [7:0] pbuf [`PAGE_BYTES];

    i2c_ee_pkg::state_t state_reg, state_next;
    logic [3:0]  cnt_reg, cnt_next;
    logic [7:0]  shift_reg, shift_next;
    logic [7:0]  addr_reg, addr_next;
    logic        drive_reg, drive_next;
    logic        rw_reg, rw_next;
    logic [7:0]  mask_reg, mask_next;
    logic [4:0]  base_reg, base_next;
    logic [2:0]  shsync_reg, shsync_next;
    logic        shadow_reg, shadow_next;
    logic [31:0] busy_reg, busy_next;
    logic        mem_we, buf_we, commit;
    logic [7:0]  rd_data;

    assign rd_data = is_reserved(addr_reg) ? 8'h00 : mem[addr_reg];

    // ==========================================================
    // Control
    always_comb begin
        state_next = state_reg;
        cnt_next   = cnt_reg;
        shift_next = shift_reg;
        addr_next  = addr_reg;
        drive_next = drive_reg;
        rw_next    = rw_reg;
        mask_next  = mask_reg;
        base_next  = base_reg;
        shsync_next = {shsync_reg[1:0], shadow_write_sel};
        shadow_next = (shsync_reg[1] == shsync_reg[2]) ? shsync_reg[2] : shadow_reg;
        busy_next  = (busy_reg != 32'h0) ? busy_reg - 32'h1 : 32'h0;
        mem_we     = 1'b0;
        buf_we     = 1'b0;
        commit     = 1'b0;
        if (lnk.stop_det) begin
            if (mask_reg != 8'h00) begin
                commit    = 1'b1;
                busy_next = NV_PROG_CYCLES;
                mask_next = 8'h00;
            end
            state_next = i2c_ee_pkg::ST_IDLE;
            drive_next = 1'b0;
        end else if (lnk.start_det) begin
            state_next = i2c_ee_pkg::ST_ADDR;
            cnt_next   = 4'h0;
            drive_next = 1'b0;
        end else begin
            case (state_reg)
                i2c_ee_pkg::ST_ADDR, i2c_ee_pkg::ST_MADDR, i2c_ee_pkg::ST_WDATA: begin
                    if (lnk.scl_rise) begin
                        shift_next = {shift_reg[6:0], lnk.sda_lvl};
                        cnt_next   = cnt_reg + 4'h1;
                    end else if (lnk.scl_fall && cnt_reg == 4'h8) begin
                        cnt_next = 4'h0;
                        if (state_reg == i2c_ee_pkg::ST_ADDR) begin
                            if (shift_reg[7:1] == {`SLAVE_ADDR_HI, lnk.strap} && busy_reg == 32'h0) begin
                                rw_next    = shift_reg[0];
                                drive_next = 1'b1;
                                state_next = i2c_ee_pkg::ST_ACK_ADDR;
                            end else begin
                                state_next = i2c_ee_pkg::ST_IGNORE;
                            end
                        end else if (state_reg == i2c_ee_pkg::ST_MADDR) begin
                            addr_next  = shift_reg;
                            drive_next = 1'b1;
                            state_next = i2c_ee_pkg::ST_ACK_MADDR;
                        end else begin
                            if (is_direct(addr_reg, shadow_reg)) begin
                                mem_we = 1'b1;
                            end else if (!is_reserved(addr_reg)) begin
                                buf_we    = 1'b1;
                                mask_next = mask_reg | (8'h01 << addr_reg[2:0]);
                                base_next = addr_reg[7:3];
                            end
                            addr_next  = {addr_reg[7:3], addr_reg[2:0] + 3'h1};
                            drive_next = 1'b1;
                            state_next = i2c_ee_pkg::ST_ACK_WDATA;
                        end
                    end
                end
                i2c_ee_pkg::ST_ACK_ADDR, i2c_ee_pkg::ST_ACK_MADDR, i2c_ee_pkg::ST_ACK_WDATA: begin
                    if (lnk.scl_fall) begin
                        drive_next = 1'b0;
                        if (state_reg == i2c_ee_pkg::ST_ACK_ADDR && rw_reg) begin
                            shift_next = rd_data;
                            addr_next  = addr_reg + 8'h01;
                            drive_next = ~rd_data[7];
                            state_next = i2c_ee_pkg::ST_TX;
                        end else if (state_reg == i2c_ee_pkg::ST_ACK_ADDR) begin
                            state_next = i2c_ee_pkg::ST_MADDR;
                        end else begin
                            state_next = i2c_ee_pkg::ST_WDATA;
                        end
                    end
                end
                i2c_ee_pkg::ST_TX: begin
                    if (lnk.scl_fall) begin
                        if (cnt_reg == 4'h7) begin
                            drive_next = 1'b0;
                            cnt_next   = 4'h0;
                            state_next = i2c_ee_pkg::ST_RACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            drive_next = ~shift_reg[6];
                            cnt_next   = cnt_reg + 4'h1;
                        end
                    end
                end
                i2c_ee_pkg::ST_RACK: begin
                    if (lnk.scl_rise && lnk.sda_lvl) begin
                        state_next = i2c_ee_pkg::ST_IGNORE;
                    end else if (lnk.scl_fall) begin
                        shift_next = rd_data;
                        addr_next  = addr_reg + 8'h01;
                        drive_next = ~rd_data[7];
                        state_next = i2c_ee_pkg::ST_TX;
                    end
                end
                i2c_ee_pkg::ST_IDLE, i2c_ee_pkg::ST_IGNORE: begin
                    drive_next = 1'b0;
                end
                default: begin
                    state_next = i2c_ee_pkg::ST_IDLE;
                    drive_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= i2c_ee_pkg::ST_IDLE;
            cnt_reg   <= 4'h0;
            shift_reg <= 8'h00;
            addr_reg  <= 8'h00;
            drive_reg <= 1'b0;
            rw_reg    <= 1'b0;
            mask_reg  <= 8'h00;
            base_reg  <= 5'h00;
            shsync_reg <= 3'h0;
            shadow_reg <= 1'b0;
            busy_reg  <= 32'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
            shift_reg <= shift_next;
            addr_reg  <= addr_next;
            drive_reg <= drive_next;
            rw_reg    <= rw_next;
            mask_reg  <= mask_next;
            base_reg  <= base_next;
            shsync_reg <= shsync_next;
            shadow_reg <= shadow_next;
            busy_reg  <= busy_next;
        end
    end

    // ==========================================================
    // Memory and page buffer
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < 256; i++) begin
                mem[i] <= `MEM_RESET;
            end
            mem[`IOCTL0_ADDR] <= `IOCTL0_RESET;
            mem[`IOCTL1_ADDR] <= `IOCTL1_RESET;
            for (int j = 0; j < `PAGE_BYTES; j++) begin
                pbuf[j] <= 8'h00;
            end
        end else begin
            if (mem_we) begin
                mem[addr_reg] <= shift_reg;
            end
            if (buf_we) begin
                pbuf[addr_reg[2:0]] <= shift_reg;
            end
            if (commit) begin
                for (int j = 0; j < `PAGE_BYTES; j++) begin
                    if (mask_reg[j]) begin
                        mem[{base_reg, 3'(j)}] <= pbuf[j];
                    end
                end
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = drive_reg;
    assign nv_busy = (busy_reg != 32'h0);
endmodule : i2c_slave_eeprom_page_access
`default_nettype wire

// ### i2c_slave_eeprom_page_access_asserts.sv
// Port checks for the two-wire EEPROM slave front end
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_eeprom_page_access_asserts #(
    parameter int unsigned NV_PROG_CYCLES = 625000
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic scl_in,
    input  wire logic sda_in,
    input  wire logic addr_strap_bit0,
    input  wire logic addr_strap_bit1,
    input  wire logic addr_strap_bit2,
    input  wire logic shadow_write_sel,
    input  wire logic sda_out,
    input  wire logic sda_oe,
    input  wire logic nv_busy
);
    logic [31:0] busy_cnt_reg;
    logic [31:0] busy_cnt_next;
    logic [7:0]  stop_age_reg;
    logic [7:0]  stop_age_next;
    logic [7:0]  oe_age_reg;
    logic [7:0]  oe_age_next;
    logic        sda_q_reg;
    logic        sda_q_next;
    // ==========
    // Helper counters
    always_comb begin
        busy_cnt_next = nv_busy ? busy_cnt_reg + 32'h1 : 32'h0;
        stop_age_next = stop_age_reg + {7'h0, stop_age_reg != 8'hFF};
        oe_age_next   = sda_oe ? 8'h00 : oe_age_reg + {7'h0, oe_age_reg != 8'hFF};
        sda_q_next    = sda_in;
        if (scl_in && sda_in && !sda_q_reg) begin
            stop_age_next = 8'h00;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busy_cnt_reg <= 32'h0;
            stop_age_reg <= 8'hFF;
            oe_age_reg   <= 8'hFF;
            sda_q_reg    <= 1'b1;
        end else begin
            busy_cnt_reg <= busy_cnt_next;
            stop_age_reg <= stop_age_next;
            oe_age_reg   <= oe_age_next;
            sda_q_reg    <= sda_q_next;
        end
    end
    // ==========
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sda_out_zero_a: assert property (sda_out == 1'b0)
        else $error("sda_out not low");
    oe_high_hold_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("sda_oe moved while clock high");
    oe_after_fall_a: assert property ($changed(sda_oe) |-> !$past(scl_in) && !$past(scl_in, 3))
        else $error("sda_oe moved too soon after clock fall");
    busy_length_a: assert property ($fell(nv_busy) |-> busy_cnt_reg == NV_PROG_CYCLES)
        else $error("programming interval length wrong");
    busy_hold_a: assert property ($rose(nv_busy) |=> nv_busy [*8])
        else $error("programming interval cut short");
    busy_after_stop_a: assert property ($rose(nv_busy) |-> stop_age_reg <= 8'h0A)
        else $error("programming began without a stop");
    busy_needs_ack_a: assert property ($rose(nv_busy) |-> oe_age_reg <= 8'h28)
        else $error("programming began without an acked byte");
    busy_no_ack_a: assert property (nv_busy |-> !sda_oe)
        else $error("data driven while programming");
    cover property ($rose(nv_busy));
    cover property ($fell(nv_busy));
    cover property ($rose(sda_oe) && !scl_in);
endmodule : i2c_slave_eeprom_page_access_asserts
bind i2c_slave_eeprom_page_access i2c_slave_eeprom_page_access_asserts #(
    .NV_PROG_CYCLES(NV_PROG_CYCLES)
) u_i2c_slave_eeprom_page_access_asserts (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .addr_strap_bit0(addr_strap_bit0), .addr_strap_bit1(addr_strap_bit1), .addr_strap_bit2(addr_strap_bit2),
    .shadow_write_sel(shadow_write_sel), .sda_out(sda_out), .sda_oe(sda_oe), .nv_busy(nv_busy));
`default_nettype wire

// ### i2c_master_model.sv
// Two-wire bus master model driving clock and data
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
    input  wire logic clk,
    input  wire logic sda_wire,
    output var logic  scl,
    output var logic  sda_m
);
    // ==========
    // Bus conditions and bits
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic start_c();
        tick(2);
        sda_m = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_m = 1'b0;
        tick(5);
        scl = 1'b0;
    endtask : start_c
    task automatic stop_c();
        tick(2);
        sda_m = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(5);
        sda_m = 1'b1;
        tick(5);
    endtask : stop_c
    task automatic bit_x(input logic b, output logic r);
        tick(2);
        sda_m = b;
        tick(4);
        scl = 1'b1;
        tick(3);
        r = sda_wire;
        tick(1);
        scl = 1'b0;
    endtask : bit_x
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], r);
        end
        bit_x(1'b1, r);
        ack = ~r;
    endtask : wbyte
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b1, d[i]);
        end
        bit_x(last, r);
    endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

// ### tb_i2c_slave_eeprom_page_access.sv
// Self-checking bench for the two-wire EEPROM slave front end
`timescale 1ns/100ps
`default_nettype none
module tb_i2c_slave_eeprom_page_access;
    typedef struct packed {logic sh; logic [7:0] a; logic [7:0] d; logic [7:0] q; logic bz;} row_t;
    logic       clk;
    logic       rst_n;
    logic       scl;
    logic       sda_m;
    logic       sda_in;
    logic [2:0] strap;
    logic       shadow_sel;
    logic       sda_out;
    logic       sda_oe;
    logic       nv_busy;
    logic       ack;
    logic [7:0] dev;
    logic [7:0] got [0:7];
    logic [7:0] wd [0:7];
    row_t       rows [0:5];
    int         err_count;
    int         checks;
    assign sda_in = sda_m & ~sda_oe;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    i2c_slave_eeprom_page_access #(.NV_PROG_CYCLES(300)) u_i2c_slave_eeprom_page_access (.clk(clk),
        .rst_n(rst_n), .scl_in(scl), .sda_in(sda_in), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
        .addr_strap_bit2(strap[2]), .shadow_write_sel(shadow_sel), .sda_out(sda_out), .sda_oe(sda_oe),
        .nv_busy(nv_busy));
    i2c_master_model u_i2c_master_model (.clk(clk), .sda_wire(sda_in), .scl(scl), .sda_m(sda_m));
    // ==========
    // Checks and bus sequences
    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk8
    task automatic chk1(input string n, input logic e, input logic g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %b seen %b", n, e, g);
        end
    endtask : chk1
    task automatic summarize();
        $display("Checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task automatic wait_idle();
        int i;
        for (i = 0; i < 400 && nv_busy !== 1'b0; i++) @(negedge clk);
        if (i == 400) begin
            err_count++;
            $display("Error nv_busy expected 0 seen 1");
            summarize();
        end
    endtask : wait_idle
    task automatic addr_w(input logic [7:0] a);
        u_i2c_master_model.start_c();
        u_i2c_master_model.wbyte(dev, ack);
        chk1("addr_ack", 1'b1, ack);
        u_i2c_master_model.wbyte(a, ack);
        chk1("maddr_ack", 1'b1, ack);
    endtask : addr_w
    task automatic wr(input logic [7:0] a, input int n);
        addr_w(a);
        for (int k = 0; k < n; k++) begin
            u_i2c_master_model.wbyte(wd[k], ack);
            chk1("data_ack", 1'b1, ack);
        end
        u_i2c_master_model.stop_c();
    endtask : wr
    task automatic rd(input logic [7:0] a, input int n, input logic cur);
        if (!cur) addr_w(a);
        u_i2c_master_model.start_c();
        u_i2c_master_model.wbyte(dev | 8'h01, ack);
        chk1("raddr_ack", 1'b1, ack);
        for (int k = 0; k < n; k++) u_i2c_master_model.rbyte(k == n - 1, got[k]);
        u_i2c_master_model.stop_c();
    endtask : rd
    // ==========
    // Main sequence
    initial begin
        rst_n = 1'b0;
        strap = 3'b101;
        shadow_sel = 1'b0;
        err_count = 0;
        checks = 0;
        rows = '{'{1'b0, 8'h03, 8'h55, 8'h55, 1'b1}, '{1'b0, 8'h45, 8'h12, 8'h00, 1'b0},
                 '{1'b0, 8'hFA, 8'hC3, 8'hC3, 1'b0}, '{1'b0, 8'hFF, 8'h3C, 8'h3C, 1'b0},
                 '{1'b1, 8'hF2, 8'h5A, 8'h5A, 1'b0}, '{1'b0, 8'hF3, 8'hA6, 8'hA6, 1'b1}};
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        dev = 8'hAA;
        for (int r = 0; r < 6; r++) begin
            shadow_sel = rows[r].sh;
            wd[0] = rows[r].d;
            wr(rows[r].a, 1);
            repeat (8) @(negedge clk);
            chk1("nv_busy", rows[r].bz, nv_busy);
            if (rows[r].bz) begin
                u_i2c_master_model.start_c();
                u_i2c_master_model.wbyte(dev, ack);
                u_i2c_master_model.stop_c();
                chk1("busy_ack", 1'b0, ack);
            end
            wait_idle();
            rd(rows[r].a, 1, 1'b0);
            chk8("read", rows[r].q, got[0]);
        end
        shadow_sel = 1'b0;
        wd = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'h00, 8'h00, 8'h00, 8'h00};
        wr(8'h16, 4);
        wait_idle();
        rd(8'h10, 7, 1'b0);
        wd = '{8'hA2, 8'hA3, 8'h00, 8'h00, 8'h00, 8'h00, 8'hA0, 8'h00};
        for (int k = 0; k < 7; k++) chk8("page", wd[k], got[k]);
        rd(8'h00, 1, 1'b1);
        chk8("current", 8'hA1, got[0]);
        rd(8'hFF, 2, 1'b0);
        chk8("roll_ff", 8'h3C, got[0]);
        chk8("roll_00", 8'h00, got[1]);
        strap = 3'b010;
        repeat (10) @(negedge clk);
        u_i2c_master_model.start_c();
        u_i2c_master_model.wbyte(dev, ack);
        chk1("old_addr", 1'b0, ack);
        u_i2c_master_model.wbyte(8'hA4, ack);
        chk1("ignored", 1'b0, ack);
        u_i2c_master_model.stop_c();
        dev = 8'hA4;
        rd(8'h03, 1, 1'b0);
        chk8("new_addr", 8'h55, got[0]);
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        chk1("rst_oe", 1'b0, sda_oe);
        chk1("rst_busy", 1'b0, nv_busy);
        chk1("rst_out", 1'b0, sda_out);
        rst_n = 1'b1;
        repeat (6) @(negedge clk);
        rd(8'hF2, 2, 1'b0);
        chk8("rst_f2", 8'hFF, got[0]);
        chk8("rst_f3", 8'h01, got[1]);
        summarize();
    end
endmodule : tb_i2c_slave_eeprom_page_access
`default_nettype wire
